// ==== verilog/smbus_client_pkg.sv ====
/*
  shared constants and carrier types of the two-wire client port
  assumes one 125 MHz clock domain on ref_clk
*/
package smbus_client_pkg;
  localparam int unsigned CLK_FREQ_HZ = 125_000_000;
  localparam logic [6:0] CLIENT_ADDR = 7'h28;
  localparam int unsigned CLK_LOW_TIMEOUT_MS = 30;
  localparam int unsigned CLK_LOW_TIMEOUT_CYC = CLK_LOW_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned BUS_IDLE_US = 200;
  localparam int unsigned BUS_IDLE_CYC = BUS_IDLE_US * (CLK_FREQ_HZ / 1_000_000);
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int unsigned SYNC_STAGES = 3;

  // register access request toward the register file
  typedef struct packed {
    logic wr;
    logic [7:0] index;
    logic [7:0] data;
  } reg_write_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } client_state_t;
endpackage

// ==== verilog/sync_fifo.sv ====
/*
  synchronous valid/ready fifo, parameter width and depth
  assumes one clock, synchronous active-high reset
*/
`timescale 1ns/10ps
module sync_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic push;
  logic pop;

  assign in_ready = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
  end
endmodule // sync_fifo

// ==== verilog/smbus_client.sv ====
/*
  two-wire client port: start/stop detect, address match, byte receive and
  transmit with acknowledge, auto-incrementing register pointer, optional
  clock-low timeout and bus-idle reset; register writes pass a fifo.
  assumes the bus pins are asynchronous and are resolved open-drain outside;
  the register file answers rd_data combinationally for rd_index.
*/
`timescale 1ns/10ps
module smbus_client
  import smbus_client_pkg::*;
#(
  parameter int unsigned CLK_LOW_TIMEOUT = CLK_LOW_TIMEOUT_CYC,
  parameter int unsigned BUS_IDLE = BUS_IDLE_CYC,
  parameter int unsigned FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus pins
  input wire logic host_serial_clock_line,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic scl_out,
  output logic scl_oe,
  // configuration and power
  input wire logic timeout_enable,
  input wire logic deep_sleep_request,
  output logic wake,
  // register file
  output logic [7:0] rd_index,
  input wire logic [7:0] rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] wr_index,
  output logic [7:0] wr_data
);
  localparam int unsigned TW = $clog2(CLK_LOW_TIMEOUT + 1);
  initial begin
    if (BUS_IDLE < 1 || CLK_LOW_TIMEOUT <= BUS_IDLE) $error("timeout counts out of range");
  end

  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_q;
    logic sda_q;
    client_state_t state;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic is_read;
    logic index_phase;
    logic [7:0] ptr;
    logic drive_low;
    logic [TW-1:0] low_cnt;
    logic [TW-1:0] idle_cnt;
    logic wake;
    logic push;
    reg_write_t wreq;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic fifo_in_ready;
  logic fifo_out_valid;
  reg_write_t fifo_out;
  logic scl_lvl;
  logic sda_lvl;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  function automatic logic agreed(input logic [2:0] s, input logic prev);
    // second and third stage agree, otherwise hold the previous level
    return (s[1] == s[2]) ? s[2] : prev;
  endfunction

  always_comb begin
    scl_lvl = agreed(st_reg.scl_sync, st_reg.scl_q);
    sda_lvl = agreed(st_reg.sda_sync, st_reg.sda_q);
    scl_rise = scl_lvl && !st_reg.scl_q;
    scl_fall = !scl_lvl && st_reg.scl_q;
    start_det = scl_lvl && st_reg.scl_q && st_reg.sda_q && !sda_lvl;
    stop_det = scl_lvl && st_reg.scl_q && !st_reg.sda_q && sda_lvl;
  end

  always_comb begin
    st_next = st_reg;
    st_next.scl_sync = {st_reg.scl_sync[1:0], host_serial_clock_line};
    st_next.sda_sync = {st_reg.sda_sync[1:0], sda_in};
    st_next.scl_q = scl_lvl;
    st_next.sda_q = sda_lvl;
    st_next.push = 1'b0;

    // back-pressure: a write waits in wreq until the fifo takes it
    if (st_reg.push && !fifo_in_ready) begin
      st_next.push = 1'b1;
    end

    // bus timeouts, only when enabled
    if (scl_lvl) begin
      st_next.low_cnt = '0;
    end else if (st_reg.low_cnt != TW'(CLK_LOW_TIMEOUT)) begin
      st_next.low_cnt = st_reg.low_cnt + 1'b1;
    end
    if (!(scl_lvl && sda_lvl)) begin
      st_next.idle_cnt = '0;
    end else if (st_reg.idle_cnt != TW'(BUS_IDLE)) begin
      st_next.idle_cnt = st_reg.idle_cnt + 1'b1;
    end

    if (start_det) begin
      st_next.state = ST_ADDR;
      st_next.bit_cnt = '0;
      st_next.drive_low = 1'b0;
    end else if (stop_det) begin
      st_next.state = ST_IDLE; // pointer kept
      st_next.drive_low = 1'b0;
      st_next.wake = 1'b0;
    end else if (timeout_enable && ((!scl_lvl && st_reg.low_cnt == TW'(CLK_LOW_TIMEOUT))
                 || (st_reg.idle_cnt == TW'(BUS_IDLE)))) begin
      st_next.state = ST_IDLE;
      st_next.drive_low = 1'b0;
      st_next.wake = 1'b0;
    end else begin
      unique case (st_reg.state)
        ST_IDLE: begin
          st_next.drive_low = 1'b0;
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            st_next.shift = {st_reg.shift[6:0], sda_lvl};
            st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
          end
          if (scl_fall && st_reg.bit_cnt == 4'h8) begin
            st_next.bit_cnt = '0;
            if (st_reg.state == ST_ADDR) begin
              if (st_reg.shift[7:1] == CLIENT_ADDR) begin
                st_next.is_read = st_reg.shift[0];
                st_next.index_phase = 1'b1;
                st_next.drive_low = 1'b1;
                st_next.wake = 1'b1;
                st_next.state = ST_ADDR_ACK;
              end else begin
                st_next.state = ST_IDLE;
              end
            end else begin
              st_next.drive_low = 1'b1;
              st_next.state = ST_RX_ACK;
              if (st_reg.index_phase) begin
                st_next.ptr = st_reg.shift;
                st_next.index_phase = 1'b0;
              end else begin
                st_next.wreq.wr = 1'b1;
                st_next.wreq.index = st_reg.ptr;
                st_next.wreq.data = st_reg.shift;
                st_next.push = 1'b1;
                st_next.ptr = st_reg.ptr + 8'h01; // wraps ff to 00
              end
            end
          end
        end
        ST_ADDR_ACK, ST_RX_ACK: begin
          if (scl_fall) begin
            if (st_reg.is_read) begin
              st_next.state = ST_TX;
              st_next.shift = rd_data;
              st_next.drive_low = !rd_data[7];
              st_next.bit_cnt = 4'h1;
            end else begin
              st_next.drive_low = 1'b0;
              st_next.state = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (st_reg.bit_cnt == 4'h8) begin
              st_next.drive_low = 1'b0;
              st_next.bit_cnt = '0;
              st_next.ptr = st_reg.ptr + 8'h01;
              st_next.state = ST_TX_ACK;
            end else begin
              st_next.drive_low = !st_reg.shift[3'(7 - st_reg.bit_cnt)];
              st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            st_next.is_read = !sda_lvl; // nack ends sending
          end
          if (scl_fall) begin
            if (st_reg.is_read) begin
              st_next.state = ST_TX;
              st_next.shift = rd_data;
              st_next.drive_low = !rd_data[7];
              st_next.bit_cnt = 4'h1;
            end else begin
              st_next.state = ST_IDLE;
            end
          end
        end
        // unused state code falls back to idle
        default: begin
          st_next.state = ST_IDLE;
          st_next.drive_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '{scl_sync: 3'h7, sda_sync: 3'h7, scl_q: 1'b1, sda_q: 1'b1, state: ST_IDLE,
                  ptr: PTR_RESET, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  sync_fifo #(
    .WIDTH($bits(reg_write_t)),
    .DEPTH(FIFO_DEPTH)
  ) write_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(st_reg.push),
    .in_ready(fifo_in_ready),
    .in_data(st_reg.wreq),
    .out_valid(fifo_out_valid),
    .out_ready(wr_ready),
    .out_data(fifo_out)
  );

  // outputs: clock line is never driven
  assign scl_out = 1'b0;
  assign scl_oe = 1'b0;
  assign sda_out = 1'b0;
  assign sda_oe = st_reg.drive_low;
  assign wake = st_reg.wake;
  assign rd_index = st_reg.ptr;
  assign wr_valid = fifo_out_valid;
  assign wr_index = fifo_out.index;
  assign wr_data = fifo_out.data;
endmodule // smbus_client

// ==== tb/smbus_client_props.sv ====
/* pin checker of the two-wire client port
   bound onto every smbus_client; sees only its ports */
`timescale 1ns/10ps
module smbus_client_props #(
  parameter int unsigned CLK_LOW_TIMEOUT = 200,
  parameter int unsigned BUS_IDLE = 50
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bus pins
  input wire logic host_serial_clock_line,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic scl_out,
  input wire logic scl_oe,
  // control and writes
  input wire logic timeout_enable,
  input wire logic wake,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [7:0] wr_index,
  input wire logic [7:0] wr_data
);
  int unsigned low_cnt;
  int unsigned idle_cnt;

  // enabled clock-low and both-high run lengths on the raw pins
  always_ff @(posedge ref_clk) begin
    low_cnt <= (rst || !timeout_enable || host_serial_clock_line) ? 0 : low_cnt + 1;
    idle_cnt <= (rst || !timeout_enable || !host_serial_clock_line || !sda_in) ? 0 : idle_cnt + 1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  scl_never_a: assert property (!scl_oe && !scl_out)
    else $error("clock line driven");
  sda_low_only_a: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  ack_addressed_a: assert property (sda_oe |-> wake)
    else $error("data pulled while not addressed");
  wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_index, wr_data}))
    else $error("write changed before taken");
  stop_release_a: assert property (host_serial_clock_line && $rose(sda_in) |-> ##[1:8] !wake)
    else $error("stop did not end transfer");
  clk_low_a: assert property (low_cnt == CLK_LOW_TIMEOUT + 8 |-> !wake)
    else $error("clock low timeout missed");
  no_timeout_a: assert property ($fell(wake) |-> timeout_enable || $past(host_serial_clock_line, 4))
    else $error("timeout while disabled");
  idle_reset_a: assert property (idle_cnt == BUS_IDLE + 8 |-> !wake)
    else $error("idle reset missed");
endmodule // smbus_client_props

bind smbus_client smbus_client_props #(.CLK_LOW_TIMEOUT(CLK_LOW_TIMEOUT), .BUS_IDLE(BUS_IDLE)) i_smbus_client_props (
  .ref_clk(ref_clk), .rst(rst), .host_serial_clock_line(host_serial_clock_line), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe), .timeout_enable(timeout_enable),
  .wake(wake), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_index(wr_index), .wr_data(wr_data)
);

// ==== tb/host_model.sv ====
/* bus master model pulling clock and data as open drain
   assumes the bench resolves both lines with pull-ups */
`timescale 1ns/10ps
module host_model #(
  parameter int unsigned QTR = 80
) (
  // clock
  input wire logic ref_clk,
  // bus
  output logic scl_low,
  output logic sda_low,
  input wire logic sda_line
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic qwait();
    repeat (QTR) @(negedge ref_clk);
  endtask

  // start or repeated start
  task automatic start();
    sda_low = 1'b0;
    qwait();
    scl_low = 1'b0;
    qwait();
    sda_low = 1'b1;
    qwait();
    scl_low = 1'b1;
    qwait();
  endtask

  task automatic stop();
    sda_low = 1'b1;
    qwait();
    scl_low = 1'b0;
    qwait();
    sda_low = 1'b0;
    qwait();
  endtask

  // four quarters keep the clock below 400 kHz
  task automatic bit_xfer(input logic b, output logic r);
    sda_low = !b;
    qwait();
    scl_low = 1'b0;
    qwait();
    r = sda_line;
    qwait();
    scl_low = 1'b1;
    qwait();
  endtask

  task automatic byte_xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r[i]);
    end
    bit_xfer(ack_in, ack);
  endtask
endmodule // host_model

// ==== tb/tb_touch_sensor_smbus_client.sv ====
/* self-checking bench of the two-wire client port
   register file modelled here, host model on the bus */
`timescale 1ns/10ps
module tb_touch_sensor_smbus_client;
  import smbus_client_pkg::*;
  logic ref_clk, rst, scl_low, sda_low, timeout_enable, deep_sleep_request, wr_ready;
  logic sda_out, sda_oe, scl_out, scl_oe, wake, wr_valid;
  logic [7:0] rd_index, wr_index, wr_data;
  logic [7:0] regs [256];
  logic [15:0] wq [$];
  int mismatches, cmp_count, cyc;
  wire logic scl_line = !(scl_low || scl_oe);
  wire logic sda_line = !(sda_low || (sda_oe && !sda_out));
  wire logic [7:0] rd_data = regs[rd_index];

  smbus_client #(.CLK_LOW_TIMEOUT(1000), .BUS_IDLE(400)) i_smbus_client (
    .ref_clk(ref_clk), .rst(rst), .host_serial_clock_line(scl_line), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe),
    .timeout_enable(timeout_enable), .deep_sleep_request(deep_sleep_request), .wake(wake),
    .rd_index(rd_index), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_index(wr_index), .wr_data(wr_data)
  );
  host_model i_host_model (.ref_clk(ref_clk), .scl_low(scl_low), .sda_low(sda_low), .sda_line(sda_line));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // register file sink
  always @(posedge ref_clk) begin
    cyc++;
    if (wr_valid && wr_ready) begin
      regs[wr_index] <= wr_data;
      wq.push_back({wr_index, wr_data});
    end
    if (cyc == 90000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic send(input logic [7:0] d, input logic want_ack);
    logic [7:0] r;
    logic a;
    i_host_model.byte_xfer(d, 1'b1, r, a);
    check({15'h0, a}, {15'h0, !want_ack});
  endtask

  task automatic recv(input logic last, input logic [7:0] want);
    logic [7:0] r;
    logic a;
    i_host_model.byte_xfer(8'hff, last, r, a);
    check({8'h0, r}, {8'h0, want});
  endtask

  task automatic t_block_write();
    wr_ready = 1'b0;
    i_host_model.start();
    send({CLIENT_ADDR, 1'b0}, 1'b1);
    send(8'hfe, 1'b1);
    for (int i = 0; i < 8; i++) send(8'h30 + i[7:0], 1'b1);
    i_host_model.stop();
    check({15'h0, wr_valid}, 16'h1);
    wr_ready = 1'b1;
    repeat (20) @(negedge ref_clk);
    check(16'(wq.size()), 16'h8);
    for (int i = 0; i < 8; i++) check(wq.pop_front(), {8'hfe + i[7:0], 8'h30 + i[7:0]});
  endtask

  task automatic t_block_read();
    i_host_model.start();
    send({CLIENT_ADDR, 1'b0}, 1'b1);
    send(8'hff, 1'b1);
    i_host_model.start();
    send({CLIENT_ADDR, 1'b1}, 1'b1);
    recv(1'b0, 8'h31);
    recv(1'b0, 8'h32);
    recv(1'b1, 8'h33);
    i_host_model.stop();
  endtask

  task automatic t_pointer();
    i_host_model.start();
    send({CLIENT_ADDR, 1'b0}, 1'b1);
    send(8'h42, 1'b1);
    i_host_model.stop();
    repeat (100) @(negedge ref_clk);
    check({8'h0, rd_index}, 16'h42);
    check(16'(wq.size()), 16'h0);
    check({15'h0, wake}, 16'h0);
    i_host_model.start();
    send({CLIENT_ADDR, 1'b1}, 1'b1);
    recv(1'b1, 8'h18);
    i_host_model.stop();
  endtask

  task automatic t_timeouts();
    deep_sleep_request = 1'b1;
    i_host_model.start();
    send({7'h29, 1'b0}, 1'b0);
    check({15'h0, wake}, 16'h0);
    i_host_model.start();
    send({CLIENT_ADDR, 1'b0}, 1'b1);
    check({15'h0, wake}, 16'h1);
    repeat (1100) @(negedge ref_clk);
    check({15'h0, wake}, 16'h1);
    timeout_enable = 1'b1;
    repeat (1100) @(negedge ref_clk);
    check({15'h0, wake}, 16'h0);
    i_host_model.start();
    send({CLIENT_ADDR, 1'b0}, 1'b1);
    i_host_model.scl_low = 1'b0;
    repeat (500) @(negedge ref_clk);
    check({15'h0, wake}, 16'h0);
    i_host_model.stop();
    timeout_enable = 1'b0;
    deep_sleep_request = 1'b0;
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    timeout_enable = 1'b0;
    deep_sleep_request = 1'b0;
    wr_ready = 1'b1;
    for (int i = 0; i < 256; i++) regs[i] = i[7:0] ^ 8'h5a;
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    t_block_write();
    t_block_read();
    t_pointer();
    t_timeouts();
    wrap_up();
  end
endmodule // tb_touch_sensor_smbus_client
